// *** design/exec_params.svh ***
// Purpose: offsets, field positions, reset values and cycle counts
// Assumes: included by the executor module and by its bench
// Notes: byte addresses on a 12-bit apb address
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// control registers
`define OFS_INSTR 12'h000
`define OFS_STAT 12'h004
`define OFS_FLAGS 12'h008
`define OFS_PC 12'h00C
`define OFS_XPTR 12'h010

// windows: 32 words each for gpr and io, data memory above
`define BASE_GPR 12'h100
`define BASE_IO 12'h200
`define BASE_DMEM 12'h400
`define WIN_MASK 12'hF80
`define DMEM_MASK 12'hC00

// status flag bit positions
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_T 6
`define FLG_I 7

// reset values
`define FLAGS_RST 8'h00
`define XPTR_RST 16'h0000

// execution lengths in core clocks
`define CYC_SHORT 2'h1
`define CYC_LONG 2'h2

`endif

// *** design/exec_pkg.sv ***
// Purpose: types shared by the executor and its bench
// Assumes: nothing
// Notes: instruction word sits in the low 28 bits of an apb write
package exec_pkg;

	// operation codes of the instruction register
	typedef enum logic [4:0] {
		NO_OPERATION = 5'h00,
		BRANCH_FLAG_SET = 5'h01,
		BRANCH_FLAG_CLEAR = 5'h02,
		BRANCH_SIGNED_GREATER_EQUAL = 5'h03,
		BRANCH_SIGNED_LESS = 5'h04,
		SET_IO_BIT = 5'h05,
		CLEAR_IO_BIT = 5'h06,
		SHIFT_LEFT_LOGICAL = 5'h07,
		SHIFT_RIGHT_LOGICAL = 5'h08,
		ROTATE_LEFT_CARRY = 5'h09,
		ROTATE_RIGHT_CARRY = 5'h0A,
		SHIFT_RIGHT_ARITHMETIC = 5'h0B,
		SWAP_NIBBLES = 5'h0C,
		FLAG_SET = 5'h0D,
		FLAG_CLEAR = 5'h0E,
		STORE_BIT_TO_TRANSFER = 5'h0F,
		LOAD_BIT_FROM_TRANSFER = 5'h10,
		COPY_REGISTER = 5'h11,
		COPY_REGISTER_PAIR = 5'h12,
		INDIRECT_LOAD = 5'h13,
		INDIRECT_LOAD_INC = 5'h14,
		INDIRECT_LOAD_DEC = 5'h15
	} op_type;

	// sequencer states
	typedef enum logic [1:0] {
		EXEC_IDLE = 2'b00,
		EXEC_FIRST = 2'b01,
		EXEC_SECOND = 2'b10
	} state_type;

	// instruction word, msb first
	typedef struct packed {
		logic [2:0] flagSel;
		logic [6:0] offset;
		logic [4:0] src;
		logic [4:0] dst;
		logic [2:0] bitSel;
		op_type op;
	} instr_type;

endpackage : exec_pkg

// *** design/cpu_branch_bit_shift_move_exec.sv ***
// Purpose: executes branch, bit, shift, flag and move instructions
// Assumes: single apb master, one clock, synchronous reset
// Notes: an instruction starts when software writes the instruction word
//
// What this block does
// - signed greater-equal branch jumps when N^V clear
// - signed less branch jumps when N^V set
// - half-carry branches test H, keep flags
// - transfer branches test T, keep flags
// - overflow branches test V, keep flags
// - interrupt branches test I, keep flags
// - set io bit forces one, two clocks
// - clear io bit forces zero, two clocks
// - left shift fills zero, sets Z C N V
// - right shift fills zero, sets Z C N V
// - rotate left through carry, one clock
// - rotate right through carry, one clock
// - flag set writes one to one flag
// - flag clear writes zero to one flag
// - bit store copies register bit to T
// - bit load copies T into register bit
// - load through X then increment X
// - decrement X then load through X
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "exec_params.svh"
module cpu_branch_bit_shift_move_exec
	import exec_pkg::*;
	#(
	parameter int PC_WIDTH = 12, // program counter width
	parameter int DMEM_DEPTH = 64 // data memory bytes
	) (
	input wire logic core_clk, // core clock
	input wire logic srst, // sync reset, high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	output logic busy, // instruction running
	output logic [PC_WIDTH-1:0] pcOut, // program counter
	output logic [7:0] statusFlags // status flags
);
	localparam int AW = $clog2(DMEM_DEPTH);

	logic [7:0] gprArr [32];
	logic [7:0] ioArr [32];
	logic [7:0] dmemArr [DMEM_DEPTH];
	logic [7:0] flags_reg;
	logic [PC_WIDTH-1:0] pc_reg;
	logic [15:0] xPtr_reg;
	instr_type instr_reg;
	state_type state_reg;
	logic [7:0] tmp_reg;
	logic taken_reg;
	logic [1:0] lastCycles_reg;
	logic busy_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign busy = busy_reg;
	assign pcOut = pc_reg;
	assign statusFlags = flags_reg;

	// apb decode; every register takes one aligned word
	wire setupPh = psel & ~penable;
	wire apbAcc = psel & penable & pready_reg;
	wire [7:0] wIdx = paddr[9:2];
	wire aligned = paddr[1:0] == 2'b00;
	wire hitInstr = paddr == `OFS_INSTR;
	wire hitStat = paddr == `OFS_STAT;
	wire hitFlags = paddr == `OFS_FLAGS;
	wire hitPc = paddr == `OFS_PC;
	wire hitX = paddr == `OFS_XPTR;
	wire hitGpr = aligned && (paddr & `WIN_MASK) == `BASE_GPR;
	wire hitIo = aligned && (paddr & `WIN_MASK) == `BASE_IO;
	wire hitDmem = aligned && (paddr & `DMEM_MASK) == `BASE_DMEM && 32'(wIdx) < DMEM_DEPTH;
	wire mapped = hitInstr | hitStat | hitFlags | hitPc | hitX | hitGpr | hitIo | hitDmem;
	// writes while busy are refused so the executor never races software
	wire refuse = ~mapped | (pwrite & (hitStat | busy_reg));
	wire apbWr = apbAcc & pwrite & ~pslverr_reg;
	wire launch = apbWr & hitInstr;

	// execution operands
	wire [4:0] dIdx = instr_reg.dst;
	wire [4:0] sIdx = instr_reg.src;
	wire [2:0] bIdx = instr_reg.bitSel;
	wire [2:0] fIdx = instr_reg.flagSel;
	wire [AW-1:0] xIdx = xPtr_reg[AW-1:0];
	wire [7:0] rdVal = gprArr[dIdx];
	wire [7:0] bitMask = 8'h01 << bIdx;
	wire [7:0] fMask = 8'h01 << fIdx;
	wire inFirst = state_reg == EXEC_FIRST;
	wire inSecond = state_reg == EXEC_SECOND;
	wire [PC_WIDTH-1:0] kExt = PC_WIDTH'($signed(instr_reg.offset));
	wire signedLess = flags_reg[`FLG_N] ^ flags_reg[`FLG_V];
	wire isBranch = instr_reg.op inside {BRANCH_FLAG_SET, BRANCH_FLAG_CLEAR,
		BRANCH_SIGNED_GREATER_EQUAL, BRANCH_SIGNED_LESS};

	// branch condition; the flag select covers H, T, V, I, N and the rest
	logic brTake;
	always_comb begin
		case (instr_reg.op)
			BRANCH_FLAG_SET: brTake = flags_reg[fIdx];
			BRANCH_FLAG_CLEAR: brTake = ~flags_reg[fIdx];
			BRANCH_SIGNED_GREATER_EQUAL: brTake = ~signedLess;
			BRANCH_SIGNED_LESS: brTake = signedLess;
			default: brTake = 1'b0;
		endcase
	end

	// io bit writes and loads need a second clock, so does a taken branch
	logic twoCycle;
	always_comb begin
		case (instr_reg.op)
			SET_IO_BIT, CLEAR_IO_BIT: twoCycle = 1'b1;
			INDIRECT_LOAD, INDIRECT_LOAD_INC, INDIRECT_LOAD_DEC: twoCycle = 1'b1;
			default: twoCycle = brTake;
		endcase
	end

	// shifter and nibble swap
	logic [7:0] shRes;
	logic shCarry;
	always_comb begin
		shRes = rdVal;
		shCarry = 1'b0;
		case (instr_reg.op)
			SHIFT_LEFT_LOGICAL: begin
				shRes = {rdVal[6:0], 1'b0};
				shCarry = rdVal[7];
			end
			SHIFT_RIGHT_LOGICAL: begin
				shRes = {1'b0, rdVal[7:1]};
				shCarry = rdVal[0];
			end
			ROTATE_LEFT_CARRY: begin
				shRes = {rdVal[6:0], flags_reg[`FLG_C]};
				shCarry = rdVal[7];
			end
			ROTATE_RIGHT_CARRY: begin
				shRes = {flags_reg[`FLG_C], rdVal[7:1]};
				shCarry = rdVal[0];
			end
			SHIFT_RIGHT_ARITHMETIC: begin
				shRes = {rdVal[7], rdVal[7:1]};
				shCarry = rdVal[0];
			end
			SWAP_NIBBLES: shRes = {rdVal[3:0], rdVal[7:4]};
			default: shRes = rdVal;
		endcase
	end

	// sequencer
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= EXEC_IDLE;
		end else begin
			case (state_reg)
				EXEC_IDLE: state_reg <= launch ? EXEC_FIRST : EXEC_IDLE;
				EXEC_FIRST: state_reg <= twoCycle ? EXEC_SECOND : EXEC_IDLE;
				default: state_reg <= EXEC_IDLE;
			endcase
		end
	end

	// busy, outcome and length of the last instruction
	always_ff @(posedge core_clk) begin
		if (srst) begin
			busy_reg <= 1'b0;
			taken_reg <= 1'b0;
			lastCycles_reg <= 2'h0;
		end else begin
			busy_reg <= launch | (inFirst & twoCycle);
			if (inFirst) begin
				taken_reg <= brTake;
				lastCycles_reg <= twoCycle ? `CYC_LONG : `CYC_SHORT;
			end
		end
	end

	// instruction word
	always_ff @(posedge core_clk) begin
		if (srst) begin
			instr_reg <= '0;
		end else if (launch) begin
			instr_reg <= instr_type'(pwdata[27:0]);
		end
	end

	// program counter; a taken branch reloads in its second clock
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pc_reg <= '0;
		end else if (apbWr && hitPc) begin
			pc_reg <= pwdata[PC_WIDTH-1:0];
		end else if (inFirst && !twoCycle) begin
			pc_reg <= pc_reg + PC_WIDTH'(1);
		end else if (inSecond) begin
			pc_reg <= pc_reg + (taken_reg ? kExt : '0) + PC_WIDTH'(1);
		end
	end

	// status flags; branches, moves and loads leave them alone
	always_ff @(posedge core_clk) begin
		if (srst) begin
			flags_reg <= `FLAGS_RST;
		end else if (apbWr && hitFlags) begin
			flags_reg <= pwdata[7:0];
		end else if (inFirst) begin
			case (instr_reg.op)
				SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL, ROTATE_LEFT_CARRY,
				ROTATE_RIGHT_CARRY, SHIFT_RIGHT_ARITHMETIC: begin
					flags_reg[`FLG_C] <= shCarry;
					flags_reg[`FLG_Z] <= shRes == 8'h00;
					flags_reg[`FLG_N] <= shRes[7];
					flags_reg[`FLG_V] <= shRes[7] ^ shCarry;
				end
				FLAG_SET: flags_reg[fIdx] <= 1'b1;
				FLAG_CLEAR: flags_reg[fIdx] <= 1'b0;
				STORE_BIT_TO_TRANSFER: flags_reg[`FLG_T] <= gprArr[sIdx][bIdx];
				default: flags_reg <= flags_reg;
			endcase
		end
	end

	// general registers; data, so no reset
	always_ff @(posedge core_clk) begin
		if (apbWr && hitGpr) begin
			gprArr[wIdx[4:0]] <= pwdata[7:0];
		end else if (inFirst) begin
			case (instr_reg.op)
				SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL, ROTATE_LEFT_CARRY, ROTATE_RIGHT_CARRY,
				SHIFT_RIGHT_ARITHMETIC, SWAP_NIBBLES: gprArr[dIdx] <= shRes;
				LOAD_BIT_FROM_TRANSFER: gprArr[dIdx][bIdx] <= flags_reg[`FLG_T];
				COPY_REGISTER: gprArr[dIdx] <= gprArr[sIdx];
				COPY_REGISTER_PAIR: begin
					gprArr[{dIdx[4:1], 1'b0}] <= gprArr[{sIdx[4:1], 1'b0}];
					gprArr[{dIdx[4:1], 1'b1}] <= gprArr[{sIdx[4:1], 1'b1}];
				end
				default: gprArr[dIdx] <= rdVal;
			endcase
		end else if (inSecond) begin
			if (instr_reg.op == INDIRECT_LOAD || instr_reg.op == INDIRECT_LOAD_INC) begin
				gprArr[dIdx] <= tmp_reg;
			end else if (instr_reg.op == INDIRECT_LOAD_DEC) begin
				gprArr[dIdx] <= dmemArr[xIdx];
			end
		end
	end

	// io registers; bit writes land in the second clock
	always_ff @(posedge core_clk) begin
		if (apbWr && hitIo) begin
			ioArr[wIdx[4:0]] <= pwdata[7:0];
		end else if (inSecond && instr_reg.op == SET_IO_BIT) begin
			ioArr[dIdx][bIdx] <= 1'b1;
		end else if (inSecond && instr_reg.op == CLEAR_IO_BIT) begin
			ioArr[dIdx][bIdx] <= 1'b0;
		end
	end

	// data memory, written by software only
	always_ff @(posedge core_clk) begin
		if (apbWr && hitDmem) begin
			dmemArr[wIdx[AW-1:0]] <= pwdata[7:0];
		end
	end

	// fetched byte; x beyond the memory wraps on its low bits
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tmp_reg <= 8'h00;
		end else if (inFirst) begin
			tmp_reg <= dmemArr[xIdx];
		end
	end

	// x pointer
	always_ff @(posedge core_clk) begin
		if (srst) begin
			xPtr_reg <= `XPTR_RST;
		end else if (apbWr && hitX) begin
			xPtr_reg <= pwdata[15:0];
		end else if (inFirst && instr_reg.op == INDIRECT_LOAD_DEC) begin
			xPtr_reg <= xPtr_reg - 16'h0001;
		end else if (inSecond && instr_reg.op == INDIRECT_LOAD_INC) begin
			xPtr_reg <= xPtr_reg + 16'h0001;
		end
	end

	// read mux
	logic [31:0] rdData;
	always_comb begin
		rdData = 32'h0000_0000;
		if (hitInstr) rdData = {4'h0, instr_reg};
		else if (hitStat) rdData = {28'h000_0000, taken_reg, busy_reg, lastCycles_reg};
		else if (hitFlags) rdData = {24'h00_0000, flags_reg};
		else if (hitPc) rdData = 32'(pc_reg);
		else if (hitX) rdData = {16'h0000, xPtr_reg};
		else if (hitGpr) rdData = {24'h00_0000, gprArr[wIdx[4:0]]};
		else if (hitIo) rdData = {24'h00_0000, ioArr[wIdx[4:0]]};
		else if (hitDmem) rdData = {24'h00_0000, dmemArr[wIdx[AW-1:0]]};
	end

	// apb answer: zero wait states, decided in the setup cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= setupPh;
			pslverr_reg <= setupPh & refuse;
			prdata_reg <= (setupPh && !pwrite && mapped) ? rdData : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	// an instruction in its first clock
	sequence startOp(op_type o);
		inFirst && instr_reg.op == o;
	endsequence

	// second clock followed by return to idle
	sequence secondThenIdle;
		inSecond ##1 (state_reg == EXEC_IDLE);
	endsequence

	wire shFlagOk = flags_reg[`FLG_Z] == (gprArr[dIdx] == 8'h00) && flags_reg[`FLG_N] == gprArr[dIdx][7]
		&& flags_reg[`FLG_V] == (flags_reg[`FLG_N] ^ flags_reg[`FLG_C]);

	branchGe_a:
		assert property (startOp(BRANCH_SIGNED_GREATER_EQUAL) ##0 !signedLess |=> secondThenIdle
			##0 (pc_reg == $past(pc_reg, 2) + kExt + PC_WIDTH'(1)))
		else $error("greater-equal branch missed its target");
	branchLt_a:
		assert property (startOp(BRANCH_SIGNED_LESS) ##0 signedLess |=> secondThenIdle
			##0 (pc_reg == $past(pc_reg, 2) + kExt + PC_WIDTH'(1)))
		else $error("less-than branch missed its target");
	branchSet_a:
		assert property (startOp(BRANCH_FLAG_SET) ##0 flags_reg[fIdx] |=> secondThenIdle
			##0 (pc_reg == $past(pc_reg, 2) + kExt + PC_WIDTH'(1) && flags_reg == $past(flags_reg, 2)))
		else $error("flag-set branch wrong");
	branchClear_a:
		assert property (startOp(BRANCH_FLAG_CLEAR) ##0 !flags_reg[fIdx] |=> secondThenIdle
			##0 (pc_reg == $past(pc_reg, 2) + kExt + PC_WIDTH'(1) && flags_reg == $past(flags_reg, 2)))
		else $error("flag-clear branch wrong");
	branchSkip_a:
		assert property (inFirst && isBranch && !brTake |=> state_reg == EXEC_IDLE
			&& pc_reg == $past(pc_reg) + PC_WIDTH'(1) && flags_reg == $past(flags_reg))
		else $error("untaken branch not one clock");
	ioSet_a:
		assert property (startOp(SET_IO_BIT) |=> secondThenIdle
			##0 (ioArr[dIdx] == ($past(ioArr[dIdx], 2) | bitMask)))
		else $error("io bit not set in two clocks");
	ioClear_a:
		assert property (startOp(CLEAR_IO_BIT) |=> secondThenIdle
			##0 (ioArr[dIdx] == ($past(ioArr[dIdx], 2) & ~bitMask)))
		else $error("io bit not cleared in two clocks");
	shiftLeft_a:
		assert property (startOp(SHIFT_LEFT_LOGICAL) |=> state_reg == EXEC_IDLE && shFlagOk
			&& gprArr[dIdx] == {$past(rdVal[6:0]), 1'b0} && flags_reg[`FLG_C] == $past(rdVal[7]))
		else $error("left shift wrong");
	shiftRight_a:
		assert property (startOp(SHIFT_RIGHT_LOGICAL) |=> shFlagOk
			&& gprArr[dIdx] == {1'b0, $past(rdVal[7:1])} && flags_reg[`FLG_C] == $past(rdVal[0]))
		else $error("right shift wrong");
	rotLeft_a:
		assert property (startOp(ROTATE_LEFT_CARRY) |=> shFlagOk
			&& gprArr[dIdx] == {$past(rdVal[6:0]), $past(flags_reg[`FLG_C])}
			&& flags_reg[`FLG_C] == $past(rdVal[7]))
		else $error("rotate left wrong");
	rotRight_a:
		assert property (startOp(ROTATE_RIGHT_CARRY) |=> shFlagOk
			&& gprArr[dIdx] == {$past(flags_reg[`FLG_C]), $past(rdVal[7:1])}
			&& flags_reg[`FLG_C] == $past(rdVal[0]))
		else $error("rotate right wrong");
	shiftArith_a:
		assert property (startOp(SHIFT_RIGHT_ARITHMETIC) |=> shFlagOk
			&& gprArr[dIdx] == {$past(rdVal[7]), $past(rdVal[7:1])} && flags_reg[`FLG_C] == $past(rdVal[0]))
		else $error("arithmetic shift wrong");
	flagSet_a:
		assert property (startOp(FLAG_SET) |=> flags_reg == ($past(flags_reg) | fMask))
		else $error("flag set touched wrong bits");
	flagClear_a:
		assert property (startOp(FLAG_CLEAR) |=> flags_reg == ($past(flags_reg) & ~fMask))
		else $error("flag clear touched wrong bits");
	bitStore_a:
		assert property (startOp(STORE_BIT_TO_TRANSFER) |=> flags_reg[`FLG_T] == $past(gprArr[sIdx][bIdx])
			&& (flags_reg & 8'hBF) == ($past(flags_reg) & 8'hBF))
		else $error("bit store wrong");
	bitLoad_a:
		assert property (startOp(LOAD_BIT_FROM_TRANSFER) |=> flags_reg == $past(flags_reg)
			&& gprArr[dIdx] == (($past(rdVal) & ~bitMask) | ({8{$past(flags_reg[`FLG_T])}} & bitMask)))
		else $error("bit load wrong");
	loadInc_a:
		assert property (startOp(INDIRECT_LOAD_INC) |=> secondThenIdle ##0 (gprArr[dIdx]
			== $past(dmemArr[xIdx], 2) && xPtr_reg == $past(xPtr_reg, 2) + 16'h0001))
		else $error("post-increment load wrong");
	loadDec_a:
		assert property (startOp(INDIRECT_LOAD_DEC) |=> (xPtr_reg == $past(xPtr_reg) - 16'h0001)
			##1 (state_reg == EXEC_IDLE && gprArr[dIdx] == $past(dmemArr[xIdx])))
		else $error("pre-decrement load wrong");
	swapNibble_a:
		assert property (startOp(SWAP_NIBBLES) |=> flags_reg == $past(flags_reg)
			&& gprArr[dIdx] == {$past(rdVal[3:0]), $past(rdVal[7:4])})
		else $error("nibble swap wrong");

endmodule : cpu_branch_bit_shift_move_exec

// *** testbench/apb_host_model.sv ***
// Purpose: apb master standing in for the software side
// Assumes: one transfer at a time, any number of wait states
// Notes: waits without a limit of its own, only the bench timeout ends a hang
`timescale 1ns/10ps
module apb_host_model (
	input wire logic core_clk, // core clock
	input wire logic pready, // slave ready
	output logic psel, // select
	output logic penable, // enable
	output logic pwrite, // direction
	output logic [11:0] paddr, // byte address
	output logic [31:0] pwdata // write data
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// request held until pready is sampled high, then released
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : apb_host_model

// *** testbench/cpu_branch_bit_shift_move_exec_tb.sv ***
// Purpose: self-checking bench for the instruction executor
// Assumes: apb slave of any latency, results visible once busy falls
// Notes: expectations queued by the driver, checked by the bus monitor
`timescale 1ns/10ps
`include "exec_params.svh"
module cpu_branch_bit_shift_move_exec_tb import exec_pkg::*;;
	typedef struct packed {logic isRead; logic err; logic [31:0] data;} note_type;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, busy, tk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, x;
	logic [11:0] pcOut;
	logic [11:0] pcExp = 12'h000;
	logic [7:0] statusFlags, fl, v, w;
	logic [4:0] d, r;
	logic [2:0] b;
	logic [15:0] xp, xa;
	logic [31:0] seed = 32'hc31e_e7dc;
	note_type notes[$];
	note_type cur;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;

	always #2 core_clk = ~core_clk;

	cpu_branch_bit_shift_move_exec dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.busy(busy), .pcOut(pcOut), .statusFlags(statusFlags));
	apb_host_model host (.core_clk(core_clk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize

	// hang guard, far above the roughly 1600 cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end

	// monitor: oldest note against each completed transfer
	always @(posedge core_clk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (notes.size() == 0) check("unexpected transfer", 32'h1, 32'h0);
			else begin
				cur = notes.pop_front();
				check("pslverr", {31'h0, pslverr}, {31'h0, cur.err});
				if (cur.isRead) check("prdata", prdata, cur.data);
			end
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic instr_type mk(op_type o, logic [2:0] b, logic [4:0] d, logic [4:0] r, logic [6:0] k,
		logic [2:0] s);
		return '{flagSel: s, offset: k, src: r, dst: d, bitSel: b, op: o};
	endfunction : mk

	function automatic logic [11:0] ga(logic [11:0] base, logic [5:0] n);
		return base + {4'h0, n, 2'b00};
	endfunction : ga

	// shift result and flags; S, H, T and I never touched
	function automatic logic [15:0] shf(int i, logic [7:0] v, logic [7:0] f);
		logic [7:0] r;
		logic c;
		case (i)
			0: {c, r} = {v, 1'b0};
			1: {r, c} = {1'b0, v};
			2: {c, r} = {v, f[`FLG_C]};
			3: {r, c} = {f[`FLG_C], v};
			4: {r, c} = {v[7], v};
			default: return {f, v[3:0], v[7:4]};
		endcase
		f[`FLG_C] = c;
		f[`FLG_Z] = (r == 8'h00);
		f[`FLG_N] = r[7];
		f[`FLG_V] = r[7] ^ c;
		return {f, r};
	endfunction : shf

	// one transfer; read data only expected when not refused
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] dt, input logic err);
		notes.push_back('{~wr & ~err, err, dt});
		host.xfer(wr, a, dt);
	endtask : bus

	// launch, optionally poke a write while busy, then check length and pc
	task automatic exec(input instr_type iw, input logic [1:0] cyc, input logic taken, input logic poke);
		int n;
		bus(1'b1, `OFS_INSTR, {4'h0, iw}, 1'b0);
		if (poke) bus(1'b1, `OFS_FLAGS, 32'h0000_00ff, 1'b1);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (busy !== 1'b0 && n < 8);
		check("busy", {31'h0, busy}, 32'h0);
		pcExp = taken ? pcExp + {{5{iw.offset[6]}}, iw.offset} + 12'h001 : pcExp + 12'h001;
		check("pcOut", {20'h0, pcOut}, {20'h0, pcExp});
		bus(1'b0, `OFS_STAT, {28'h0, taken, 1'b0, cyc}, 1'b0);
		bus(1'b0, `OFS_PC, {20'h0, pcExp}, 1'b0);
	endtask : exec

	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		// reset values, unmapped read and read-only status
		bus(1'b0, `OFS_FLAGS, {24'h0, `FLAGS_RST}, 1'b0);
		bus(1'b0, `OFS_XPTR, {16'h0, `XPTR_RST}, 1'b0);
		bus(1'b0, 12'h020, 32'h0, 1'b1);
		bus(1'b1, `OFS_STAT, 32'h1, 1'b1);
		// flag branches, both polarities of every flag
		for (int s = 0; s < 8; s++) for (int m = 0; m < 4; m++) begin
			x = rnd();
			fl = x[7:0];
			fl[s] = m[1];
			bus(1'b1, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			tk = m[1] ^ m[0];
			exec(mk(m[0] ? BRANCH_FLAG_CLEAR : BRANCH_FLAG_SET, 3'h0, 5'h0, 5'h0, x[14:8], s[2:0]),
				tk ? `CYC_LONG : `CYC_SHORT, tk, 1'b0);
			bus(1'b0, `OFS_FLAGS, {24'h0, fl}, 1'b0);
		end
		// signed branches over all N, V pairs
		for (int m = 0; m < 8; m++) begin
			x = rnd();
			fl = x[7:0];
			fl[`FLG_N] = m[0];
			fl[`FLG_V] = m[1];
			bus(1'b1, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			tk = (m[0] ^ m[1]) == m[2];
			exec(mk(m[2] ? BRANCH_SIGNED_LESS : BRANCH_SIGNED_GREATER_EQUAL, 3'h0, 5'h0, 5'h0, x[14:8], 3'h0),
				tk ? `CYC_LONG : `CYC_SHORT, tk, 1'b0);
			bus(1'b0, `OFS_FLAGS, {24'h0, fl}, 1'b0);
		end
		// flag set and clear, every flag
		for (int s = 0; s < 16; s++) begin
			x = rnd();
			fl = x[7:0];
			bus(1'b1, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			exec(mk(s[3] ? FLAG_CLEAR : FLAG_SET, 3'h0, 5'h0, 5'h0, 7'h0, s[2:0]), `CYC_SHORT, 1'b0, 1'b0);
			fl[s[2:0]] = ~s[3];
			bus(1'b0, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			check("statusFlags", {24'h0, statusFlags}, {24'h0, fl});
		end
		// shifts, rotates and swap, two random values each
		for (int i = 0; i < 12; i++) begin
			x = rnd();
			fl = x[7:0];
			v = x[15:8];
			d = x[20:16];
			bus(1'b1, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			bus(1'b1, ga(`BASE_GPR, {1'b0, d}), {24'h0, v}, 1'b0);
			exec(mk(op_type'(5'h07 + 5'(i / 2)), 3'h0, d, 5'h0, 7'h0, 3'h0), `CYC_SHORT, 1'b0, 1'b0);
			{fl, v} = shf(i / 2, v, fl);
			bus(1'b0, ga(`BASE_GPR, {1'b0, d}), {24'h0, v}, 1'b0);
			bus(1'b0, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			check("statusFlags", {24'h0, statusFlags}, {24'h0, fl});
		end
		// io bit set and clear; half of them poked by a refused write
		for (int i = 0; i < 4; i++) begin
			x = rnd();
			v = x[15:8];
			b = x[7:5];
			bus(1'b1, ga(`BASE_IO, {1'b0, x[4:0]}), {24'h0, v}, 1'b0);
			exec(mk(i[0] ? CLEAR_IO_BIT : SET_IO_BIT, b, x[4:0], 5'h0, 7'h0, 3'h0), `CYC_LONG, 1'b0, i[1]);
			v[b] = ~i[0];
			bus(1'b0, ga(`BASE_IO, {1'b0, x[4:0]}), {24'h0, v}, 1'b0);
			bus(1'b0, `OFS_FLAGS, {24'h0, fl}, 1'b0);
		end
		// bit store to transfer flag, then bit load back
		for (int i = 0; i < 4; i++) begin
			x = rnd();
			fl = x[7:0];
			v = x[15:8];
			d = x[20:16];
			b = x[23:21];
			bus(1'b1, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			bus(1'b1, ga(`BASE_GPR, {1'b0, d}), {24'h0, v}, 1'b0);
			exec(mk(STORE_BIT_TO_TRANSFER, b, 5'h0, d, 7'h0, 3'h0), `CYC_SHORT, 1'b0, 1'b0);
			fl[`FLG_T] = v[b];
			bus(1'b0, `OFS_FLAGS, {24'h0, fl}, 1'b0);
			exec(mk(LOAD_BIT_FROM_TRANSFER, x[26:24], d, 5'h0, 7'h0, 3'h0), `CYC_SHORT, 1'b0, 1'b0);
			v[x[26:24]] = fl[`FLG_T];
			bus(1'b0, ga(`BASE_GPR, {1'b0, d}), {24'h0, v}, 1'b0);
			bus(1'b0, `OFS_FLAGS, {24'h0, fl}, 1'b0);
		end
		// pair copy between even registers, then a single move
		x = rnd();
		d = {x[3:0], 1'b0};
		r = {x[7:4], 1'b0} ^ 5'h10;
		v = x[15:8];
		w = x[23:16];
		bus(1'b1, ga(`BASE_GPR, {1'b0, r}), {24'h0, v}, 1'b0);
		bus(1'b1, ga(`BASE_GPR, {1'b0, r} + 6'h01), {24'h0, w}, 1'b0);
		exec(mk(COPY_REGISTER_PAIR, 3'h0, d, r, 7'h0, 3'h0), `CYC_SHORT, 1'b0, 1'b0);
		bus(1'b0, ga(`BASE_GPR, {1'b0, d}), {24'h0, v}, 1'b0);
		bus(1'b0, ga(`BASE_GPR, {1'b0, d} + 6'h01), {24'h0, w}, 1'b0);
		exec(mk(COPY_REGISTER, 3'h0, d + 5'h01, r, 7'h0, 3'h0), `CYC_SHORT, 1'b0, 1'b0);
		bus(1'b0, ga(`BASE_GPR, {1'b0, d} + 6'h01), {24'h0, v}, 1'b0);
		// a no-op only advances pc, and its word reads back
		exec(mk(NO_OPERATION, x[2:0], x[7:3], x[12:8], x[19:13], x[22:20]), `CYC_SHORT, 1'b0, 1'b0);
		bus(1'b0, `OFS_INSTR, {4'h0, mk(NO_OPERATION, x[2:0], x[7:3], x[12:8], x[19:13], x[22:20])}, 1'b0);
		// loads through the pointer: plain, post-increment, pre-decrement
		for (int o = 0; o < 6; o++) begin
			x = rnd();
			xp = x[15:0];
			xa = (o % 3 == 2) ? xp - 16'h0001 : xp;
			bus(1'b1, `OFS_XPTR, {16'h0, xp}, 1'b0);
			bus(1'b1, ga(`BASE_DMEM, xa[5:0]), {24'h0, x[23:16]}, 1'b0);
			exec(mk(op_type'(5'h13 + 5'(o % 3)), 3'h0, x[28:24], 5'h0, 7'h0, 3'h0), `CYC_LONG, 1'b0, 1'b0);
			xa = (o % 3 == 1) ? xp + 16'h0001 : xa;
			bus(1'b0, ga(`BASE_GPR, {1'b0, x[28:24]}), {24'h0, x[23:16]}, 1'b0);
			bus(1'b0, `OFS_XPTR, {16'h0, xa}, 1'b0);
		end
		// mid-run reset brings pc, flags and pointer back to their reset values
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		check("pcOut after reset", {20'h0, pcOut}, 32'h0);
		check("statusFlags after reset", {24'h0, statusFlags}, {24'h0, `FLAGS_RST});
		bus(1'b0, `OFS_XPTR, {16'h0, `XPTR_RST}, 1'b0);
		@(posedge core_clk);
		// a transfer that never completed leaves a note behind
		check("notes left", notes.size(), 32'h0);
		summarize();
	end
endmodule : cpu_branch_bit_shift_move_exec_tb
